/* bench/fssc_host.sv */
// Host model issuing read-any and write-any register commands.
// Assumes the device takes a command on the rising edge of i_clk.
`timescale 1ns/1ns
`default_nettype none
module fssc_host
(
  input  wire logic                            i_clk,
  input  wire logic [fssc_pkg::REG_DATA_W-1:0] i_rdata,
  input  wire logic                            i_rdata_valid,
  output logic                                 o_valid,
  output logic      [7:0]                      o_opcode,
  output logic      [fssc_pkg::REG_ADDR_W-1:0] o_addr,
  output logic      [fssc_pkg::REG_DATA_W-1:0] o_wdata
);
  import fssc_pkg::*;

  // Released address and write data flip so a stale value is never mistaken for a live one
  task automatic idle();
    o_valid = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  initial
  begin
    o_valid = 1'b0;
    o_opcode = 8'h00;
    o_addr = '0;
    o_wdata = 8'h00;
  end

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_opcode = OP_WRITE_ANY;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    idle();
  endtask

  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_opcode = OP_READ_ANY;
    o_addr = a;
    @(negedge i_clk);
    idle();
    // Answer is due by the falling edge right after the taking edge; late counts as lost
    d = (i_rdata_valid === 1'b1) ? i_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* bench/fssc_regs_test.sv */
// Self-checking bench for the suspend-status and configuration registers.
// Assumes the host model drives the command bus; bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module fssc_regs_test;
  import fssc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cv;
  logic [7:0] cop;
  logic [23:0] cad;
  logic [7:0] cwd;
  logic [7:0] rdat;
  logic rval;
  logic esus = 1'b0;
  logic psus = 1'b0;
  logic est = 1'b0;
  logic edn = 1'b0;
  logic [8:0] esec = 9'h000;
  logic q = 1'b0;
  logic [8:0] qsec = 9'h000;
  logic uni = 1'b0;
  logic pwm = 1'b0;
  logic [26:0] radr = 27'h0000000;
  logic pfl, pbv, ssh, quad, frz, ral;
  int err_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  fssc_host u_host (.i_clk(clk), .i_rdata(rdat), .i_rdata_valid(rval),
    .o_valid(cv), .o_opcode(cop), .o_addr(cad), .o_wdata(cwd));

  fssc_regs u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(cv),
    .I_CMD_OPCODE(cop), .I_CMD_ADDR(cad), .I_CMD_WDATA(cwd), .O_RDATA(rdat),
    .O_RDATA_VALID(rval), .I_ERASE_SUSPENDED(esus), .I_PROGRAM_SUSPENDED(psus),
    .I_ERASE_START(est), .I_ERASE_DONE(edn), .I_ERASE_SECTOR(esec),
    .I_ERASE_OUTCOME_BIT_QUERY(q), .I_ERASE_OUTCOME_BIT_SECTOR(qsec), .I_UNIFORM_SECTORS(uni),
    .I_READ_PASSWORD_MODE(pwm), .I_READ_ADDR(radr), .O_PROTECT_FROM_LOW(pfl),
    .O_PROTECT_BITS_VOLATILE(pbv), .O_SMALL_SECTORS_HIGH(ssh),
    .O_QUAD_MODE(quad), .O_PROTECT_FROZEN(frz), .O_READ_ALLOWED(ral));

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: byte %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: bit %b exp %b", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [23:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk8(d, e);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // Writes in the first cycle after release are dropped
    repeat (3) @(negedge clk);
  endtask

  task automatic set_read(input logic p, input logic [26:0] a);
    @(negedge clk);
    pwm = p;
    radr = a;
    #1;
  endtask

  task automatic query(input logic [8:0] s);
    @(negedge clk);
    q = 1'b1;
    qsec = s;
    @(negedge clk);
    q = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse_erase(input logic st, input logic [8:0] s);
    @(negedge clk);
    est = st;
    edn = ~st;
    esec = s;
    @(negedge clk);
    est = 1'b0;
    edn = 1'b0;
  endtask

  task automatic t_reset_values();
    rdchk(ADDR_SUSPEND_STATE, 8'h00);
    rdchk(ADDR_PERSIST_CFG, 8'h00);
    rdchk(ADDR_VOLATILE_CFG, 8'h00);
    rdchk(24'h00_0007, 8'h00);
  endtask

  task automatic t_config();
    set_read(1'b1, 27'h0000000);
    chk1(ral, 1'b1);
    set_read(1'b1, 27'h0040000);
    chk1(ral, 1'b0);
    u_host.wr(ADDR_PERSIST_CFG, 8'hFF);
    rdchk(ADDR_PERSIST_CFG, 8'h2E);
    rdchk(ADDR_VOLATILE_CFG, 8'h2C);
    chk1(pfl, 1'b1);
    chk1(pbv, 1'b1);
    chk1(ssh, 1'b1);
    set_read(1'b1, 27'h7FFFFFF);
    chk1(ral, 1'b1);
    set_read(1'b1, 27'h0000000);
    chk1(ral, 1'b0);
    set_read(1'b0, 27'h0000000);
    chk1(ral, 1'b1);
    @(negedge clk);
    uni = 1'b1;
    #1;
    chk1(ssh, 1'b0);
    u_host.wr(ADDR_PERSIST_CFG, 8'h00);
    rdchk(ADDR_PERSIST_CFG, 8'h2C);
    u_host.wr(ADDR_VOLATILE_CFG, 8'hFF);
    rdchk(ADDR_VOLATILE_CFG, 8'h2F);
    chk1(quad, 1'b1);
    chk1(frz, 1'b1);
    u_host.wr(ADDR_VOLATILE_CFG, 8'h00);
    rdchk(ADDR_VOLATILE_CFG, 8'h2D);
    chk1(quad, 1'b0);
  endtask

  task automatic t_erase();
    query(9'h006);
    rdchk(ADDR_SUSPEND_STATE, 8'h04);
    pulse_erase(1'b1, 9'h005);
    query(9'h005);
    rdchk(ADDR_SUSPEND_STATE, 8'h00);
    esus = 1'b1;
    query(9'h006);
    rdchk(ADDR_SUSPEND_STATE, 8'h02);
    esus = 1'b0;
    pulse_erase(1'b0, 9'h005);
    query(9'h005);
    rdchk(ADDR_SUSPEND_STATE, 8'h04);
  endtask

  task automatic t_suspend();
    query(9'h005);
    @(negedge clk);
    esus = 1'b1;
    psus = 1'b1;
    u_host.wr(ADDR_SUSPEND_STATE, 8'h00);
    // Outcome bit keeps the last accepted query through the suspend
    rdchk(ADDR_SUSPEND_STATE, 8'h07);
    esus = 1'b0;
    rdchk(ADDR_SUSPEND_STATE, 8'h05);
    psus = 1'b0;
    u_host.wr(ADDR_SUSPEND_STATE, 8'hFF);
    rdchk(ADDR_SUSPEND_STATE, 8'h04);
  endtask

  task automatic t_lock();
    do_reset();
    u_host.wr(ADDR_VOLATILE_CFG, 8'h01);
    u_host.wr(ADDR_PERSIST_CFG, 8'h20);
    rdchk(ADDR_PERSIST_CFG, 8'h00);
    chk1(pfl, 1'b0);
    chk1(frz, 1'b1);
  endtask

  // Whole run is about 120 cycles; this margin is generous
  initial
  begin
    #200000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    do_reset();
    t_reset_values();
    t_config();
    t_erase();
    t_suspend();
    t_lock();
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/fssc_erase_map.sv */
// Per-sector erase completion map with registered read data.
// Assumes start and done strokes come from the erase engine on the same clock.
`timescale 1ns/1ns
`default_nettype none
module fssc_erase_map
(
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_start,
  input  wire logic                          i_done,
  input  wire logic [fssc_pkg::SECTOR_W-1:0] i_wsector,
  input  wire logic                          i_rd,
  input  wire logic [fssc_pkg::SECTOR_W-1:0] i_rsector,
  output logic                               o_completed
);

  import fssc_pkg::*;

  typedef struct packed {
    logic [SECTOR_COUNT-1:0] done_map;
    logic                    rdata;
  } fssc_map_s;

  fssc_map_s s_reg;
  fssc_map_s s_next;

  always_comb
  begin
    s_next = s_reg;
    // Start clears the mark so an erase cut short reads as not completed
    if (i_start)
    begin
      s_next.done_map[i_wsector] = 1'b0;
    end
    else if (i_done)
    begin
      s_next.done_map[i_wsector] = 1'b1;
    end
    if (i_rd)
    begin
      s_next.rdata = s_reg.done_map[i_rsector];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_reg <= '{done_map: ERASE_MAP_RESET, rdata: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_completed = s_reg.rdata;

endmodule
`default_nettype wire

/* verilog/fssc_pkg.sv */
// Shared constants for the suspend-status and configuration register bank.
// Assumes an 8-bit register path reached by read-any and write-any commands.
package fssc_pkg;

  localparam int REG_DATA_W = 8;
  localparam int REG_ADDR_W = 24;

  // Command opcodes
  localparam logic [7:0] OP_READ_ANY  = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;

  // Register addresses on the any-register path
  localparam logic [REG_ADDR_W-1:0] ADDR_SUSPEND_STATE = 24'h00_0001;
  localparam logic [REG_ADDR_W-1:0] ADDR_PERSIST_CFG   = 24'h00_0002;
  localparam logic [REG_ADDR_W-1:0] ADDR_VOLATILE_CFG  = 24'h80_0002;

  // Suspend state register fields
  localparam int BIT_ERASE_OUTCOME = 2;
  localparam int BIT_ERASE_PAUSED  = 1;
  localparam int BIT_WRITE_PAUSED  = 0;

  // Configuration register fields
  localparam int BIT_PROT_ORIGIN = 5;
  localparam int BIT_PROT_VOLAT  = 3;
  localparam int BIT_SMALL_PLACE = 2;
  localparam int BIT_WIDE_IO     = 1;
  localparam int BIT_LOCK        = 0;

  // Field masks
  localparam logic [7:0] SUSPEND_DEF_MASK = 8'h07;
  localparam logic [7:0] PERSIST_OTP_MASK = 8'h2C;
  localparam logic [7:0] PERSIST_RW_MASK  = 8'h02;
  localparam logic [7:0] VOL_COPY_MASK    = 8'h2C;
  localparam logic [7:0] VOL_RW_MASK      = 8'h03;

  // Reset values and unmapped read data
  localparam logic [7:0] SUSPEND_RESET = 8'h00;
  localparam logic [7:0] PERSIST_RESET = 8'h00;
  localparam logic [1:0] VOL_RW_RESET  = 2'h0;
  localparam logic [7:0] RDATA_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Array geometry
  localparam int SECTOR_COUNT     = 512;
  localparam int SECTOR_W         = 9;
  localparam int ARRAY_ADDR_W     = 27;
  localparam int BOOT_RANGE_KB    = 256;
  localparam int BOOT_RANGE_BYTES = BOOT_RANGE_KB * 1024;
  localparam int BOOT_ADDR_W      = $clog2(BOOT_RANGE_BYTES);

  localparam logic [SECTOR_COUNT-1:0] ERASE_MAP_RESET = '1;

endpackage

/* verilog/fssc_regs.sv */
// Suspend/erase status register and configuration registers of the flash.
// Assumes the command decoder and erase engine run on I_CLK; no pin inputs.
`timescale 1ns/1ns
`default_nettype none
module fssc_regs
(
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_CMD_VALID,
  input  wire logic [7:0]                    I_CMD_OPCODE,
  input  wire logic [fssc_pkg::REG_ADDR_W-1:0] I_CMD_ADDR,
  input  wire logic [fssc_pkg::REG_DATA_W-1:0] I_CMD_WDATA,
  output logic      [fssc_pkg::REG_DATA_W-1:0] O_RDATA,
  output logic                               O_RDATA_VALID,
  input  wire logic                          I_ERASE_SUSPENDED,
  input  wire logic                          I_PROGRAM_SUSPENDED,
  input  wire logic                          I_ERASE_START,
  input  wire logic                          I_ERASE_DONE,
  input  wire logic [fssc_pkg::SECTOR_W-1:0] I_ERASE_SECTOR,
  input  wire logic                          I_ERASE_OUTCOME_BIT_QUERY,
  input  wire logic [fssc_pkg::SECTOR_W-1:0] I_ERASE_OUTCOME_BIT_SECTOR,
  input  wire logic                          I_UNIFORM_SECTORS,
  input  wire logic                          I_READ_PASSWORD_MODE,
  input  wire logic [fssc_pkg::ARRAY_ADDR_W-1:0] I_READ_ADDR,
  output logic                               O_PROTECT_FROM_LOW,
  output logic                               O_PROTECT_BITS_VOLATILE,
  output logic                               O_SMALL_SECTORS_HIGH,
  output logic                               O_QUAD_MODE,
  output logic                               O_PROTECT_FROZEN,
  output logic                               O_READ_ALLOWED
);

  import fssc_pkg::*;

  typedef struct packed {
    logic [7:0] suspend;
    logic [7:0] persist;
    logic [1:0] vol_rw;
    logic       loaded;
    logic       query_pending;
    logic [7:0] rdata;
    logic       rvalid;
  } fssc_state_s;

  fssc_state_s s_reg;
  fssc_state_s s_next;
  logic        erase_completed;
  logic        is_read;
  logic        is_write;
  logic        any_suspend;
  logic [7:0]  volatile_view;
  logic [ARRAY_ADDR_W-BOOT_ADDR_W-1:0] boot_region;

  fssc_erase_map u_erase_map (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_start     (I_ERASE_START),
    .i_done      (I_ERASE_DONE),
    .i_wsector   (I_ERASE_SECTOR),
    .i_rd        (I_ERASE_OUTCOME_BIT_QUERY),
    .i_rsector   (I_ERASE_OUTCOME_BIT_SECTOR),
    .o_completed (erase_completed)
  );

  assign is_read     = I_CMD_VALID && (I_CMD_OPCODE == OP_READ_ANY);
  assign is_write    = I_CMD_VALID && (I_CMD_OPCODE == OP_WRITE_ANY);
  assign any_suspend = I_ERASE_SUSPENDED || I_PROGRAM_SUSPENDED;
  // Volatile copies track persistent OTP bits directly
  assign volatile_view = (s_reg.persist & VOL_COPY_MASK)
                       | (8'(s_reg.vol_rw) & VOL_RW_MASK);

  always_comb
  begin
    s_next        = s_reg;
    s_next.rvalid = 1'b0;
    s_next.suspend[BIT_ERASE_PAUSED] = I_ERASE_SUSPENDED;
    s_next.suspend[BIT_WRITE_PAUSED] = I_PROGRAM_SUSPENDED;
    // Query during suspend is dropped; the bit keeps its old value
    s_next.query_pending = I_ERASE_OUTCOME_BIT_QUERY && !any_suspend;
    if (s_reg.query_pending)
    begin
      s_next.suspend[BIT_ERASE_OUTCOME] = erase_completed;
    end
    // Power-up defaults of the volatile bits, one cycle after reset
    if (!s_reg.loaded)
    begin
      s_next.loaded = 1'b1;
      s_next.vol_rw[BIT_WIDE_IO] = s_reg.persist[BIT_WIDE_IO];
      s_next.vol_rw[BIT_LOCK]    = s_reg.persist[BIT_LOCK];
    end
    else if (is_write)
    begin
      if (I_CMD_ADDR == ADDR_PERSIST_CFG)
      begin
        // OTP bits only ever set; zero writes leave them, no fault raised
        if (!s_reg.vol_rw[BIT_LOCK])
        begin
          s_next.persist = (s_reg.persist | (I_CMD_WDATA & PERSIST_OTP_MASK))
                           & PERSIST_OTP_MASK;
        end
        else
        begin
          s_next.persist = s_reg.persist & PERSIST_OTP_MASK;
        end
        s_next.persist[BIT_WIDE_IO] = I_CMD_WDATA[BIT_WIDE_IO];
      end
      else if (I_CMD_ADDR == ADDR_VOLATILE_CFG)
      begin
        s_next.vol_rw[BIT_WIDE_IO] = I_CMD_WDATA[BIT_WIDE_IO];
        // Lock is set-only; cleared by reset alone
        s_next.vol_rw[BIT_LOCK] = s_reg.vol_rw[BIT_LOCK] | I_CMD_WDATA[BIT_LOCK];
      end
    end
    if (is_read)
    begin
      s_next.rvalid = 1'b1;
      if (I_CMD_ADDR == ADDR_SUSPEND_STATE)
      begin
        s_next.rdata = s_reg.suspend & SUSPEND_DEF_MASK;
      end
      else if (I_CMD_ADDR == ADDR_PERSIST_CFG)
      begin
        s_next.rdata = s_reg.persist & (PERSIST_OTP_MASK | PERSIST_RW_MASK);
      end
      else if (I_CMD_ADDR == ADDR_VOLATILE_CFG)
      begin
        s_next.rdata = volatile_view;
      end
      else
      begin
        s_next.rdata = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s_reg <= '{suspend: SUSPEND_RESET, persist: PERSIST_RESET, vol_rw: VOL_RW_RESET,
                 loaded: 1'b0, query_pending: 1'b0, rdata: RDATA_RESET, rvalid: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign O_RDATA                 = s_reg.rdata;
  assign O_RDATA_VALID           = s_reg.rvalid;
  assign O_PROTECT_FROM_LOW      = s_reg.persist[BIT_PROT_ORIGIN];
  assign O_PROTECT_BITS_VOLATILE = s_reg.persist[BIT_PROT_VOLAT];
  assign O_SMALL_SECTORS_HIGH    = s_reg.persist[BIT_SMALL_PLACE] && !I_UNIFORM_SECTORS;
  assign O_QUAD_MODE             = s_reg.vol_rw[BIT_WIDE_IO];
  assign O_PROTECT_FROZEN        = s_reg.vol_rw[BIT_LOCK];

  // Origin 0 leaves the lowest range readable, origin 1 the highest
  assign boot_region = I_READ_ADDR[ARRAY_ADDR_W-1:BOOT_ADDR_W];
  assign O_READ_ALLOWED = !I_READ_PASSWORD_MODE
                        || (s_reg.persist[BIT_PROT_ORIGIN] ? (&boot_region)
                                                           : !(|boot_region));

  property p_erase_paused;
    @(posedge I_CLK) disable iff (!I_RST_N)
    I_ERASE_SUSPENDED |=> s_reg.suspend[BIT_ERASE_PAUSED];
  endproperty
  a_erase_paused: assert property (p_erase_paused) else $error("erase paused flag lags");

  property p_write_paused;
    @(posedge I_CLK) disable iff (!I_RST_N)
    !I_PROGRAM_SUSPENDED |=> !s_reg.suspend[BIT_WRITE_PAUSED];
  endproperty
  a_write_paused: assert property (p_write_paused) else $error("write paused flag stuck");

  property p_origin_sticky;
    @(posedge I_CLK) disable iff (!I_RST_N)
    s_reg.persist[BIT_PROT_ORIGIN] |=> O_PROTECT_FROM_LOW;
  endproperty
  a_origin_sticky: assert property (p_origin_sticky) else $error("origin bit cleared");

  property p_lock_sticky;
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_PROTECT_FROZEN |=> O_PROTECT_FROZEN && $stable(O_PROTECT_FROM_LOW)
                         && $stable(O_PROTECT_BITS_VOLATILE);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock or OTP changed");

  property p_read_answer;
    @(posedge I_CLK) disable iff (!I_RST_N)
    is_read |=> O_RDATA_VALID ##1 !O_RDATA_VALID || $past(is_read);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");

  property p_suspend_reserved;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (is_read && I_CMD_ADDR == ADDR_SUSPEND_STATE) |=> (O_RDATA[7:3] == 5'h00);
  endproperty
  a_suspend_reserved: assert property (p_suspend_reserved) else $error("reserved bits set");

  property p_volatile_copy;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (is_read && I_CMD_ADDR == ADDR_VOLATILE_CFG) |=>
      ((O_RDATA & VOL_COPY_MASK) == ($past(s_reg.persist) & VOL_COPY_MASK));
  endproperty
  a_volatile_copy: assert property (p_volatile_copy) else $error("volatile copy mismatch");

  property p_quad_default;
    @(posedge I_CLK) disable iff (!I_RST_N)
    $rose(s_reg.loaded) |-> (O_QUAD_MODE == s_reg.persist[BIT_WIDE_IO]);
  endproperty
  a_quad_default: assert property (p_quad_default) else $error("wide-io default wrong");

  property p_outcome_from_map;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_ERASE_OUTCOME_BIT_QUERY && !any_suspend) |=> ##1
      (s_reg.suspend[BIT_ERASE_OUTCOME] == $past(erase_completed));
  endproperty
  a_outcome_from_map: assert property (p_outcome_from_map) else $error("outcome bit wrong");

  property p_boot_window;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_READ_PASSWORD_MODE && !O_PROTECT_FROM_LOW && (|boot_region)) |-> !O_READ_ALLOWED;
  endproperty
  a_boot_window: assert property (p_boot_window) else $error("read outside boot range");

endmodule
`default_nettype wire
